// ==== bench/peer_board.sv ====
`default_nettype none
module peer_board (
	input wire logic lead_clk, // peer is clock leader
	input wire logic arm_req, // peer raises arm
	input wire logic trig_req, // peer detects trigger
	input wire logic sync_clk_o, // board clock out
	input wire logic sync_clk_oe, // board clock drive
	input wire logic arm_bus_o, // board arm out
	input wire logic arm_bus_oe, // board arm drive
	input wire logic trig_bus_o, // board trigger out
	input wire logic trig_bus_oe, // board trigger drive
	output logic sync_clk_i, // clock line
	output logic arm_bus_i, // arm line
	output logic trig_bus_i // trigger line
);
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	// 160 ns, odd phase; stands still unless this peer leads
	initial begin
		#7;
		forever begin
			#80;
			pclk = lead_clk ? ~pclk : 1'b0;
		end
	end
	// one clock leader at a time: peer yields while board drives
	assign sync_clk_i = sync_clk_oe ? sync_clk_o : pclk;
	// lines are OR of drivers; peer arm_req is ORed in whatever lead_clk is
	assign arm_bus_i = (arm_bus_oe & arm_bus_o) | arm_req;
	assign trig_bus_i = (trig_bus_oe & trig_bus_o) | trig_req;
endmodule : peer_board
`default_nettype wire

// ==== bench/sync_role_setup_checker.sv ====
`include "sync_role_params.svh"
`default_nettype none
module sync_role_setup_checker (
	input wire logic clk_sys, // clock
	input wire logic rst_b, // reset, low active
	input wire logic [19:0] s_axi_awaddr, // aw addr
	input wire logic s_axi_awvalid, // aw valid
	input wire logic s_axi_awready, // aw ready
	input wire logic [31:0] s_axi_wdata, // w data
	input wire logic [3:0] s_axi_wstrb, // w strobes
	input wire logic s_axi_wvalid, // w valid
	input wire logic s_axi_wready, // w ready
	input wire logic s_axi_bvalid, // b valid
	input wire logic arm_bus_i, // arm line
	input wire logic sync_clk_oe, // clock drive
	input wire logic trig_bus_oe, // trigger drive
	input wire logic arm_bus_oe, // arm drive
	input wire logic board_start, // start pulse
	input wire logic board_armed, // armed
	input wire logic clk_from_bus // clock follower
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	logic [19:0] wa_reg;
	logic [31:0] wd_reg;
	logic wf_reg, free_reg;
	wire cmd_w = wa_reg == `OFS_COMMAND && wf_reg;
	wire lt_w = wa_reg == `OFS_LOCAL_TRIG && wf_reg;
	// keep the taken write; partial strobes are not decoded here
	// free_reg drops once sync-off or local-only could mask a role
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wa_reg <= '0;
			wd_reg <= '0;
			wf_reg <= 1'b0;
			free_reg <= 1'b1;
		end else begin
			if (s_axi_awvalid && s_axi_awready) wa_reg <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready) wd_reg <= s_axi_wdata;
			if (s_axi_wvalid && s_axi_wready) wf_reg <= s_axi_wstrb == 4'hF;
			if ($rose(s_axi_bvalid) && (lt_w || (cmd_w && wd_reg == `CMD_SYNC_OFF)))
				free_reg <= 1'b0;
		end
	end
	sequence wr_done(logic [31:0] c);
		$rose(s_axi_bvalid) && cmd_w && wd_reg == c && free_reg;
	endsequence
	sequence lt_on;
		$rose(s_axi_bvalid) && lt_w && wd_reg[0];
	endsequence
	// sync off is checked even after local-only, since it clears every role
	sequence off_done;
		$rose(s_axi_bvalid) && cmd_w && wd_reg == `CMD_SYNC_OFF;
	endsequence
	chk_clk_leader: assert property (wr_done(`CMD_CLK_LEADER) |-> ##[0:2] sync_clk_oe)
		else $error("clock leader not driving");
	chk_clk_follow: assert property (wr_done(`CMD_CLK_FOLLOWER) |-> ##[0:2] clk_from_bus && !sync_clk_oe)
		else $error("clock follower not taken");
	chk_trig_leader: assert property (wr_done(`CMD_TRIG_LEADER) |-> ##[0:2] trig_bus_oe)
		else $error("trigger leader not driving");
	chk_sync_off: assert property (off_done |-> ##[0:2] !sync_clk_oe && !trig_bus_oe && !clk_from_bus)
		else $error("sync off left a role");
	chk_local_only: assert property (lt_on |-> ##[0:2] (!trig_bus_oe) [*3])
		else $error("local-only board drives trigger");
	chk_roles_held: assert property ($changed(sync_clk_oe) || $changed(clk_from_bus) |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("clock role changed without write");
	chk_arm_leader: assert property (wr_done(`CMD_ARM_ALL) ##0 sync_clk_oe |-> ##[0:3] board_armed && arm_bus_oe)
		else $error("leader did not arm");
	chk_arm_follow: assert property (clk_from_bus && $rose(arm_bus_i) && !board_armed |-> ##[1:6] board_armed)
		else $error("follower did not arm");
	chk_start_pulse: assert property (board_start |-> ($past(board_armed) || $past(board_armed, 2)) ##1 !board_start)
		else $error("start not one armed cycle");
endmodule : sync_role_setup_checker
bind sync_role_setup sync_role_setup_checker chk (.clk_sys, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.arm_bus_i, .sync_clk_oe, .trig_bus_oe, .arm_bus_oe, .board_start, .board_armed, .clk_from_bus);
`default_nettype wire

// ==== bench/sync_role_setup_tb.sv ====
`include "sync_role_params.svh"
`default_nettype none
module sync_role_setup_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, seen;
	logic [19:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd, cmd;
	logic [3:0] s_axi_wstrb, hub_version, roles;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic hub_star, local_trig, sync_clk_i, sync_clk_o, sync_clk_oe, trig_bus_i, trig_bus_o;
	logic trig_bus_oe, arm_bus_i, arm_bus_o, arm_bus_oe, board_start, board_armed, clk_from_bus;
	logic lead_clk, arm_req, trig_req;
	int n_fail, checks_done, k;
	logic [31:0] codes [4] = '{`CMD_CLK_LEADER, `CMD_TRIG_LEADER, `CMD_CLK_FOLLOWER,
		`CMD_TRIG_FOLLOWER};
	sync_role_setup dut (.clk_sys, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .hub_star, .hub_version, .local_trig, .sync_clk_i,
		.sync_clk_o, .sync_clk_oe, .trig_bus_i, .trig_bus_o, .trig_bus_oe, .arm_bus_i,
		.arm_bus_o, .arm_bus_oe, .board_start, .board_armed, .clk_from_bus);
	peer_board peer (.lead_clk, .arm_req, .trig_req, .sync_clk_o, .sync_clk_oe, .arm_bus_o,
		.arm_bus_oe, .trig_bus_o, .trig_bus_oe, .sync_clk_i, .arm_bus_i, .trig_bus_i);
	// role model: clock role in [3:2], trigger role in [1:0]
	function automatic logic [3:0] next_roles(logic [3:0] r, logic [31:0] c);
		case (c)
			`CMD_CLK_LEADER: return {2'h1, r[1:0]};
			`CMD_CLK_FOLLOWER: return {2'h2, r[1:0]};
			`CMD_TRIG_LEADER: return {r[3:2], 2'h1};
			`CMD_TRIG_FOLLOWER: return {r[3:2], 2'h2};
			default: return r;
		endcase
	endfunction : next_roles
	function automatic logic or_ok(logic star, logic [3:0] ver);
		return star && ver >= `OR_MIN_HUB_VER;
	endfunction : or_ok
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// every wait is bounded; running out counts as a mismatch
	task automatic tick(inout int n);
		@(posedge clk_sys);
		n++;
		if (n > 300) begin
			n_fail++;
			$display("unexpected %0t: wait ran out", $time);
			stop_test();
		end
	endtask : tick
	task automatic wr(input logic [19:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		logic aw, w;
		n = 0;
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		while (aw || w || s_axi_bvalid !== 1'b1) begin
			tick(n);
			if (aw && s_axi_awready) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		// bready stays high, so a following call never assigns it twice in one step
		r = s_axi_bresp;
	endtask : wr
	task automatic rd_reg(input logic [19:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic ar;
		n = 0;
		ar = 1'b1;
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		while (ar || s_axi_rvalid !== 1'b1) begin
			tick(n);
			if (ar && s_axi_arready) begin
				ar = 1'b0;
				s_axi_arvalid <= 1'b0;
			end
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask : rd_reg
	task automatic peer_arm();
		int n;
		n = 0;
		arm_req <= 1'b1;
		while (board_armed !== 1'b1) tick(n);
		arm_req <= 1'b0;
	endtask : peer_arm
	// pulse own or peer trigger long enough for the synchronisers, then watch for start
	task automatic fire(input logic own, output logic s);
		if (own) local_trig <= 1'b1;
		else trig_req <= 1'b1;
		repeat (3) @(posedge clk_sys);
		{local_trig, trig_req} <= 2'h0;
		s = 1'b0;
		repeat (40) begin
			@(posedge clk_sys);
			s = s | board_start;
		end
	endtask : fire
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		{rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{hub_star, local_trig, lead_clk, arm_req, trig_req} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, hub_version, roles} = '0;
		s_axi_wstrb = 4'hF;
		n_fail = 0;
		checks_done = 0;
		void'($urandom(97328));
		repeat (16) @(posedge clk_sys);
		rst_b <= 1'b1;
		rd_reg(`OFS_COMMAND, rd, rs);
		chk(rd, `RST_COMMAND);
		rd_reg(`OFS_LOCAL_TRIG, rd, rs);
		chk(32'(rd[0]), 32'h0);
		wr(20'h00100, 32'h5, rs);
		chk(32'(rs), 32'(`RESP_SLVERR));
		rd_reg(20'h00100, rd, rs);
		chk({rd[29:0], rs}, 32'(`RESP_SLVERR));
		// no waveform memory here: the host load is taken as done before roles
		// random role commands mixed with codes that must leave roles alone
		for (int i = 0; i < 16; i++) begin
			k = int'($urandom % 5);
			cmd = (k == 4) ? ($urandom | 32'h00010000) : codes[k];
			wr(`OFS_COMMAND, cmd, rs);
			roles = next_roles(roles, cmd);
			rd_reg(`OFS_STATUS, rd, rs);
			chk(32'(rd[3:0]), 32'(roles));
			rd_reg(`OFS_COMMAND, rd, rs);
			chk(rd, cmd);
			chk(32'(sync_clk_oe), 32'(roles[3:2] == 2'h1));
			chk(32'(clk_from_bus), 32'(roles[3:2] == 2'h2));
			chk(32'(trig_bus_oe), 32'(roles[1:0] == 2'h1));
		end
		wr(`OFS_COMMAND, `CMD_CLK_LEADER, rs);
		wr(`OFS_COMMAND, `CMD_TRIG_LEADER, rs);
		// the clock leader's line toggles once every half period
		k = 0;
		seen = sync_clk_o;
		repeat (16) begin
			@(posedge clk_sys);
			k += int'(sync_clk_o !== seen);
			seen = sync_clk_o;
		end
		chk(32'(k), 32'(16 / `SYNC_HALF_CYC));
		// star hub new enough, cascade, old hub; this hub board leads
		for (int t = 0; t < 3; t++) begin
			hub_star <= t != 1;
			hub_version <= 4'((t == 2) ? $urandom % 4 : 4 + $urandom % 12);
			repeat (4) @(posedge clk_sys);
			wr(`OFS_COMMAND, `CMD_ARM_ALL, rs);
			@(posedge clk_sys);
			chk(32'(board_armed), 32'h1);
			chk(32'(arm_bus_o), 32'h1);
			fire(1'b0, seen);
			chk(32'(seen), 32'(or_ok(hub_star, hub_version)));
			if (!seen) begin
				fire(1'b1, seen);
				chk(32'({seen, trig_bus_o}), 32'h3);
			end
		end
		wr(`OFS_COMMAND, `CMD_CLK_FOLLOWER, rs);
		wr(`OFS_COMMAND, `CMD_TRIG_FOLLOWER, rs); // one trigger role each
		lead_clk <= 1'b1;
		peer_arm();
		fire(1'b0, seen);
		chk(32'(seen), 32'h1);
		// exclusion after follower role
		wr(`OFS_LOCAL_TRIG, 32'h1, rs);
		rd_reg(`OFS_LOCAL_TRIG, rd, rs);
		chk(32'(rd[0]), 32'h1);
		peer_arm();
		fire(1'b0, seen);
		chk(32'(seen), 32'h0);
		fire(1'b1, seen);
		chk(32'(seen), 32'h1);
		wr(`OFS_COMMAND, `CMD_SYNC_OFF, rs);
		rd_reg(`OFS_STATUS, rd, rs);
		chk(rd & 32'h4F, 32'h40);
		chk(32'({sync_clk_oe, clk_from_bus, trig_bus_oe}), 32'h0);
		wr(`OFS_COMMAND, `CMD_ARM_ALL, rs);
		fire(1'b1, seen);
		chk(32'(seen), 32'h1);
		stop_test();
	end
endmodule : sync_role_setup_tb
`default_nettype wire

// ==== rtl/sync_role_params.svh ====
`ifndef SYNC_ROLE_PARAMS_SVH
`define SYNC_ROLE_PARAMS_SVH
// register byte addresses
`define OFS_COMMAND 20'h00000
`define OFS_STATUS 20'h00004
`define OFS_LOCAL_TRIG 20'h30D68
// command codes
`define CMD_CLK_LEADER 32'h00000064
`define CMD_TRIG_LEADER 32'h00000065
`define CMD_CLK_FOLLOWER 32'h0000006E
`define CMD_TRIG_FOLLOWER 32'h0000006F
`define CMD_SYNC_OFF 32'h00000078
`define CMD_ARM_ALL 32'h00000082
// reset values and fields
`define RST_COMMAND 32'h00000000
`define LOCAL_TRIG_BIT 0
`define OR_MIN_HUB_VER 4'h4
// timing: shared clock period and system clock period in ns
`define SYNC_CLK_PERIOD_NS 160
`define SYS_CLK_PERIOD_NS 20
`define SYNC_HALF_CYC (`SYNC_CLK_PERIOD_NS / (2 * `SYS_CLK_PERIOD_NS))
// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== rtl/sync_role_pkg.sv ====
`default_nettype none
package sync_role_pkg;
	typedef enum logic [1:0] {TRIG_NONE, TRIG_LEADER, TRIG_FOLLOWER} trig_role_e;
	typedef enum logic [1:0] {CLK_OWN, CLK_LEADER, CLK_FOLLOWER} clk_role_e;
	typedef enum logic [1:0] {ARM_IDLE, ARM_WAIT, ARM_FIRED} arm_state_e;
	// status word layout
	typedef struct packed {
		logic [20:0] zero;
		logic or_ok;
		logic local_only;
		logic sync_off;
		arm_state_e arm;
		clk_role_e clk_role;
		trig_role_e trig_role;
	} status_s;
endpackage : sync_role_pkg
`default_nettype wire

// ==== rtl/sync_role_setup.sv ====
// Operation
// RULE1 - host loads waveform memory before syncing
// RULE2 - code 101 makes board trigger leader
// RULE3 - host sets at least one trigger leader
// RULE4 - star hub: leader triggers OR-combined
// RULE5 - no OR with cascade or hub below V4
// RULE6 - OR leaders share one trigger mode
// RULE7 - OR only if hub board leads
// RULE8 - code 111 makes board trigger follower
// RULE9 - host gives each board one trigger role
// RULE10 - local-only register uses own trigger
// RULE11 - host sets follower before excluding board
// RULE12 - remaining shared boards share trigger modes
// RULE13 - code 100 makes board drive shared clock
// RULE14 - host sets one clock leader only
// RULE15 - code 110 takes clock from bus
// RULE16 - host makes all others clock followers
// RULE17 - code 130 arms all boards first
// RULE18 - host arms only via clock leader
// RULE19 - code 120 disables synchronization, run alone
// RULE20 - roles held until new command or reset
`include "sync_role_params.svh"
`default_nettype none
module sync_role_setup (
	input wire logic clk_sys, // system clock, 50 MHz
	input wire logic rst_b, // async reset, low active
	input wire logic [19:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [19:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic hub_star, // strap: star hub topology
	input wire logic [3:0] hub_version, // strap: hub hardware version
	input wire logic local_trig, // own trigger detection pin
	input wire logic sync_clk_i, // shared clock line in
	output logic sync_clk_o, // shared clock line out
	output logic sync_clk_oe, // shared clock drive enable
	input wire logic trig_bus_i, // shared trigger line in
	output logic trig_bus_o, // shared trigger line out
	output logic trig_bus_oe, // shared trigger drive enable
	input wire logic arm_bus_i, // shared arm line in
	output logic arm_bus_o, // shared arm line out
	output logic arm_bus_oe, // shared arm drive enable
	output logic board_start, // one-cycle start to board core
	output logic board_armed, // board armed, waiting for trigger
	output logic clk_from_bus // sample clock taken from bus
);
	// rising edge of a level that was already synchronised
	function automatic logic rise(input logic prev, input logic cur);
		rise = cur & ~prev;
	endfunction : rise
	// merge write data under byte strobes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction : merge
	// pin synchronisers: first stage feeds only the second; bit 8 is the shared clock
	logic [8:0] pin_s1_reg;
	logic [8:0] pin_s2_reg;
	logic [3:0] pin_prev_reg;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1_reg <= 9'h000;
			pin_s2_reg <= 9'h000;
			pin_prev_reg <= 4'h0;
		end else begin
			pin_s1_reg <= {sync_clk_i, hub_version, hub_star, local_trig, trig_bus_i, arm_bus_i};
			pin_s2_reg <= pin_s1_reg;
			pin_prev_reg <= {pin_s2_reg[8], pin_s2_reg[2:0]};
		end
	end
	wire arm_edge = rise(pin_prev_reg[0], pin_s2_reg[0]);
	wire bus_trig_edge = rise(pin_prev_reg[1], pin_s2_reg[1]);
	wire own_trig_edge = rise(pin_prev_reg[2], pin_s2_reg[2]);
	wire bus_clk_edge = rise(pin_prev_reg[3], pin_s2_reg[8]);
	// OR-combine only on a star hub of version V4 or later
	wire or_ok = pin_s2_reg[3] & (pin_s2_reg[7:4] >= `OR_MIN_HUB_VER); // [RULE5]
	// axi write channel: address and data taken in either order
	logic aw_have_reg;
	logic w_have_reg;
	logic [19:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	wire aw_take = s_axi_awvalid & ~aw_have_reg;
	wire w_take = s_axi_wvalid & ~w_have_reg;
	wire wr_go = aw_have_reg & w_have_reg & ~bvalid_reg;
	wire wr_cmd = wr_go & (aw_addr_reg == `OFS_COMMAND);
	wire wr_loc = wr_go & (aw_addr_reg == `OFS_LOCAL_TRIG);
	wire wr_sts = wr_go & (aw_addr_reg == `OFS_STATUS);
	wire wr_ok = wr_cmd | wr_loc | wr_sts;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_addr_reg <= 20'h00000;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (w_take) begin
				w_have_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end
	// ready flags are registered: high while the holding slot is free
	assign s_axi_awready = ~aw_have_reg;
	assign s_axi_wready = ~w_have_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	// command decode on the merged write value
	logic [31:0] cmd_reg;
	logic local_only_reg;
	wire [31:0] cmd_val = merge(cmd_reg, w_data_reg, w_strb_reg);
	wire [31:0] loc_val = merge({31'h0, local_only_reg}, w_data_reg, w_strb_reg);
	wire c_trig_lead = wr_cmd & (cmd_val == `CMD_TRIG_LEADER);
	wire c_trig_fol = wr_cmd & (cmd_val == `CMD_TRIG_FOLLOWER);
	wire c_clk_lead = wr_cmd & (cmd_val == `CMD_CLK_LEADER);
	wire c_clk_fol = wr_cmd & (cmd_val == `CMD_CLK_FOLLOWER);
	wire c_off = wr_cmd & (cmd_val == `CMD_SYNC_OFF);
	wire c_arm = wr_cmd & (cmd_val == `CMD_ARM_ALL);
	// role registers; unknown codes leave the roles untouched
	sync_role_pkg::trig_role_e trig_role_reg;
	sync_role_pkg::clk_role_e clk_role_reg;
	logic sync_off_reg;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cmd_reg <= `RST_COMMAND;
			local_only_reg <= 1'b0;
			trig_role_reg <= sync_role_pkg::TRIG_NONE;
			clk_role_reg <= sync_role_pkg::CLK_OWN;
			sync_off_reg <= 1'b0;
		end else begin
			if (wr_cmd) begin
				cmd_reg <= cmd_val;
			end
			if (wr_loc) begin
				local_only_reg <= loc_val[`LOCAL_TRIG_BIT];
			end
			if (c_trig_lead) begin
				trig_role_reg <= sync_role_pkg::TRIG_LEADER; // [RULE2] [RULE20]
				sync_off_reg <= 1'b0;
			end else if (c_trig_fol) begin
				trig_role_reg <= sync_role_pkg::TRIG_FOLLOWER; // [RULE8] [RULE20]
				sync_off_reg <= 1'b0;
			end else if (c_clk_lead) begin
				clk_role_reg <= sync_role_pkg::CLK_LEADER; // [RULE13] [RULE20]
				sync_off_reg <= 1'b0;
			end else if (c_clk_fol) begin
				clk_role_reg <= sync_role_pkg::CLK_FOLLOWER; // [RULE15] [RULE20]
				sync_off_reg <= 1'b0;
			end else if (c_off) begin
				trig_role_reg <= sync_role_pkg::TRIG_NONE; // [RULE19]
				clk_role_reg <= sync_role_pkg::CLK_OWN;
				sync_off_reg <= 1'b1;
			end
		end
	end
	wire is_clk_lead = (clk_role_reg == sync_role_pkg::CLK_LEADER);
	wire is_clk_fol = (clk_role_reg == sync_role_pkg::CLK_FOLLOWER);
	wire is_trig_lead = (trig_role_reg == sync_role_pkg::TRIG_LEADER);
	wire is_trig_fol = (trig_role_reg == sync_role_pkg::TRIG_FOLLOWER);
	wire on_shared = ~sync_off_reg & ~local_only_reg;
	// own clock divider makes the shared clock and the local tick
	logic [7:0] div_reg;
	logic sclk_out_reg;
	wire div_end = (div_reg == 8'(`SYNC_HALF_CYC - 1));
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			div_reg <= 8'h00;
			sclk_out_reg <= 1'b0;
		end else begin
			div_reg <= div_end ? 8'h00 : div_reg + 8'h01;
			if (div_end) begin
				sclk_out_reg <= ~sclk_out_reg;
			end
		end
	end
	wire own_tick = div_end & ~sclk_out_reg;
	// followers step on the bus clock, others on their own divider
	wire tick = is_clk_fol ? bus_clk_edge : own_tick; // [RULE15]
	// trigger source by role; leaders also hear peers when OR is allowed
	wire lead_src = own_trig_edge | (or_ok & bus_trig_edge); // [RULE4]
	wire shared_src = is_trig_lead ? lead_src : (is_trig_fol & bus_trig_edge);
	wire trig_src = on_shared ? shared_src : own_trig_edge; // [RULE10] [RULE19]
	// arming sequence: no trigger counts until the board is armed
	sync_role_pkg::arm_state_e arm_reg;
	sync_role_pkg::arm_state_e arm_next;
	logic pend_reg;
	logic start_reg;
	logic trig_drv_reg;
	wire arm_req = (c_arm & (is_clk_lead | sync_off_reg)) | (is_clk_fol & ~sync_off_reg & arm_edge);
	always_comb begin
		arm_next = arm_reg;
		case (arm_reg)
			sync_role_pkg::ARM_IDLE: begin
				if (arm_req) begin
					arm_next = sync_role_pkg::ARM_WAIT; // [RULE17]
				end
			end
			sync_role_pkg::ARM_WAIT: begin
				if (pend_reg && tick) begin
					arm_next = sync_role_pkg::ARM_FIRED;
				end
			end
			sync_role_pkg::ARM_FIRED: begin
				if (arm_req) begin
					arm_next = sync_role_pkg::ARM_WAIT;
				end
			end
			default: arm_next = sync_role_pkg::ARM_IDLE;
		endcase
	end
	wire waiting = (arm_reg == sync_role_pkg::ARM_WAIT);
	wire fire = waiting & pend_reg & tick;
	// pending trigger waits for the next shared clock tick so boards align
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			arm_reg <= sync_role_pkg::ARM_IDLE;
			pend_reg <= 1'b0;
			start_reg <= 1'b0;
			trig_drv_reg <= 1'b0;
		end else begin
			arm_reg <= arm_next;
			start_reg <= fire;
			if (waiting && trig_src) begin
				pend_reg <= 1'b1; // set wins over clear
			end else if (fire || !waiting) begin
				pend_reg <= 1'b0;
			end
			// a leader holds the trigger line until rearmed so slow peers see it
			if (arm_req) begin
				trig_drv_reg <= 1'b0;
			end else if (waiting && own_trig_edge && is_trig_lead && on_shared) begin
				trig_drv_reg <= 1'b1; // [RULE4]
			end
		end
	end
	// line drivers and status outputs, all registered
	logic sclk_oe_reg;
	logic armed_reg;
	logic trig_oe_reg;
	logic arm_o_reg;
	logic arm_oe_reg;
	logic from_bus_reg;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sclk_oe_reg <= 1'b0;
			trig_oe_reg <= 1'b0;
			arm_o_reg <= 1'b0;
			arm_oe_reg <= 1'b0;
			from_bus_reg <= 1'b0;
			armed_reg <= 1'b0;
		end else begin
			sclk_oe_reg <= is_clk_lead; // [RULE13]
			trig_oe_reg <= is_trig_lead & on_shared;
			arm_o_reg <= waiting & is_clk_lead; // [RULE17]
			arm_oe_reg <= is_clk_lead;
			from_bus_reg <= is_clk_fol; // [RULE15]
			armed_reg <= (arm_next == sync_role_pkg::ARM_WAIT); // [RULE17]
		end
	end
	assign sync_clk_o = sclk_out_reg;
	assign sync_clk_oe = sclk_oe_reg;
	assign trig_bus_o = trig_drv_reg;
	assign trig_bus_oe = trig_oe_reg;
	assign arm_bus_o = arm_o_reg;
	assign arm_bus_oe = arm_oe_reg;
	assign board_start = start_reg;
	assign board_armed = armed_reg;
	assign clk_from_bus = from_bus_reg;
	// read channel: one cycle from address to data
	sync_role_pkg::status_s sts;
	assign sts = '{zero: 21'h0, or_ok: or_ok, local_only: local_only_reg,
		sync_off: sync_off_reg, arm: arm_reg, clk_role: clk_role_reg,
		trig_role: trig_role_reg};
	wire r_cmd = (s_axi_araddr == `OFS_COMMAND);
	wire r_sts = (s_axi_araddr == `OFS_STATUS);
	wire r_loc = (s_axi_araddr == `OFS_LOCAL_TRIG);
	wire [31:0] r_word = r_cmd ? cmd_reg : r_sts ? 32'(sts) :
		r_loc ? {31'h0, local_only_reg} : 32'h00000000;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= `RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_reg) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= r_word;
			rresp_reg <= (r_cmd | r_sts | r_loc) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end
	assign s_axi_arready = ~rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
endmodule : sync_role_setup
`default_nettype wire
